// ===== hw/adccfg_regs.vh
// Purpose: constants for the converter setup register block
// Assumes: 16-bit setup word, serial link in clock-polarity-0 phase-1 form
// Notes:   field positions, reset value and encodings
`ifndef ADCCFG_REGS_VH
`define ADCCFG_REGS_VH

`define ACFG_WIDTH        16
`define ACFG_RESET        16'h058B
`define ACFG_START_BIT    15
`define ACFG_INSEL_HI     14
`define ACFG_INSEL_LO     12
`define ACFG_GAIN_HI      11
`define ACFG_GAIN_LO      9
`define ACFG_MODE_BIT     8
`define ACFG_RATE_HI      7
`define ACFG_RATE_LO      5
`define ACFG_TEMP_BIT     4
`define ACFG_PULL_BIT     3
`define ACFG_WVC_HI       2
`define ACFG_WVC_LO       1
`define ACFG_RSVD_BIT     0
`define ACFG_WVC_VALID    2'h1
`define ACFG_MODE_CONT    1'b0
`define ACFG_MODE_SINGLE  1'b1
// full-scale range codes, millivolts
`define ACFG_FSR_6144     16'h1800
`define ACFG_FSR_4096     16'h1000
`define ACFG_FSR_2048     16'h0800
`define ACFG_FSR_1024     16'h0400
`define ACFG_FSR_512      16'h0200
`define ACFG_FSR_256      16'h0100
// input pair codes: {positive, negative}, 3'h4 means ground
`define ACFG_IN_GND       3'h4
// conversion time stand-in, in cycles of clk
`define ACFG_CONV_CYCLES  16'h0040

`endif

// ===== hw/adccfg_setup_reg.v
// Purpose: converter setup register loaded and read back over the serial link
// Assumes: sclk/csN/din come from the host's clock domain; clk is 10 MHz
// Notes:   conversion core is modelled only as a busy counter
//
// How it works
// - start bit launches conversion only when idle
// - start bit always reads back zero
// - input select picks the converter input pair
// - gain field sets full-scale range
// - gain codes 101 to 111 give 256 mV
// - mode bit zero means continuous conversion
// - mode bit one means single-shot, reset default
// - rate field sets samples per second
// - temperature bit selects internal sensor
// - pull-up on data out while deselected
// - no pull-up means data out floats deselected
// - update only when write code is 01
// - write code resets to 01
// - host writes reserved bit one, readback ignored
// - continuous mode converts back to back always
// - setup bits sampled on falling serial edges
// - word written first returns in last half when write code is 01
`timescale 1ns/100ps
`default_nettype none
`include "adccfg_regs.vh"

module adccfg_setup_reg #(
	parameter CONV_CYCLES = 64
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// serial link
	input  wire        sclk,
	input  wire        csN,
	input  wire        din,
	input  wire [15:0] conversionResult,
	output reg         serialOutReady,
	output reg         serialOutReadyOe,
	output reg         serialOutPullup,
	// decoded setup for the analog core
	output reg  [2:0]  inputPositive,
	output reg  [2:0]  inputNegative,
	output reg  [15:0] fullScaleRange,
	output reg  [9:0]  samplesPerSecond,
	output reg         tempSenseSelect,
	output reg         singleShotMode,
	output reg         converterBusy,
	output reg  [15:0] setupWord
);

	// two-flop synchronisers for the link inputs
	reg [1:0] sclkSync_reg;
	reg [1:0] csSync_reg;
	reg [1:0] dinSync_reg;
	reg       sclkLast_reg;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sclkSync_reg <= 2'h0;
			csSync_reg   <= 2'h3;
			dinSync_reg  <= 2'h0;
			sclkLast_reg <= 1'b0;
		end else begin
			sclkSync_reg <= {sclkSync_reg[0], sclk};
			csSync_reg   <= {csSync_reg[0], csN};
			dinSync_reg  <= {dinSync_reg[0], din};
			sclkLast_reg <= sclkSync_reg[1];
		end
	end

	wire sclkRise = sclkSync_reg[1] & ~sclkLast_reg;
	wire sclkFall = ~sclkSync_reg[1] & sclkLast_reg;
	wire selected = ~csSync_reg[1];

	// stored setup; bit 15 is never held
	reg  [14:0] setup_reg;
	reg  [15:0] shiftIn_reg;
	reg  [31:0] shiftOut_reg;
	reg  [5:0]  bitCount_reg;
	reg  [15:0] convCount_reg;
	reg         convActive_reg;
	reg         dataFresh_reg;
	reg  [15:0] resultHold_reg;
	reg         frameStarted_reg;
	// full reset word; bit 15 is dropped on purpose when stored
	localparam [15:0] RESET_WORD = `ACFG_RESET;

	wire [15:0] incoming = {shiftIn_reg[14:0], dinSync_reg[1]};
	wire        wordDone = selected & sclkFall & (bitCount_reg == 6'd15);
	wire        wordOk   = incoming[`ACFG_WVC_HI:`ACFG_WVC_LO] == `ACFG_WVC_VALID;
	wire        powerDown = setup_reg[`ACFG_MODE_BIT] & ~convActive_reg;
	wire        startReq = wordDone & wordOk & incoming[`ACFG_START_BIT]
			& incoming[`ACFG_MODE_BIT] & powerDown;
	wire        convDone = convActive_reg & (convCount_reg == 16'h0000);
	// readback view: start bit forced low
	wire [15:0] readback = {1'b0, setup_reg};

	// serial shift: sample on falling, launch on rising
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			setup_reg    <= RESET_WORD[14:0];
			shiftIn_reg  <= 16'h0000;
			shiftOut_reg <= 32'h0000_0000;
			bitCount_reg <= 6'd0;
			frameStarted_reg <= 1'b0;
		end else if (!selected) begin
			bitCount_reg <= 6'd0;
			frameStarted_reg <= 1'b0;
			shiftOut_reg <= {resultHold_reg, readback};
		end else begin
			if (sclkFall) begin
				shiftIn_reg  <= incoming;
				if (bitCount_reg != 6'd32)
					bitCount_reg <= bitCount_reg + 6'd1;
				// first word lands; later halves never reload
				if (wordDone && wordOk) begin
					setup_reg <= incoming[14:0];
					// second half now returns what was just written
					// fifteen shifts done, so the readback half now sits one bit below the top
					shiftOut_reg[30:15] <= {1'b0, incoming[14:0]};
				end
			end
			if (sclkRise && bitCount_reg != 6'd0)
				shiftOut_reg <= {shiftOut_reg[30:0], 1'b0};
			// first rise keeps the result MSB in place and ends the ready phase
			if (sclkRise)
				frameStarted_reg <= 1'b1;
		end
	end

	// conversion engine stand-in
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			convActive_reg <= 1'b0;
			convCount_reg  <= 16'h0000;
			dataFresh_reg  <= 1'b0;
			resultHold_reg <= 16'h0000;
		end else begin
			if (convDone) begin
				convActive_reg <= 1'b0;
				resultHold_reg <= conversionResult;
				dataFresh_reg  <= 1'b1;
			end else if (selected && sclkRise && bitCount_reg == 6'd0) begin
				dataFresh_reg  <= 1'b0;
			end
			// continuous mode relaunches regardless of chip select
			if ((convDone || !convActive_reg) && !setup_reg[`ACFG_MODE_BIT]) begin
				convActive_reg <= 1'b1;
				convCount_reg  <= CONV_CYCLES[15:0];
			end else if (startReq) begin
				convActive_reg <= 1'b1;
				convCount_reg  <= CONV_CYCLES[15:0];
			end else if (convActive_reg) begin
				convCount_reg  <= convCount_reg - 16'h0001;
			end
		end
	end

	// registered pin and decode outputs
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			serialOutReady   <= 1'b1;
			serialOutReadyOe <= 1'b0;
			serialOutPullup  <= 1'b1;
			inputPositive    <= 3'h0;
			inputNegative    <= 3'h1;
			fullScaleRange   <= `ACFG_FSR_2048;
			samplesPerSecond <= 10'd128;
			tempSenseSelect  <= 1'b0;
			singleShotMode   <= 1'b1;
			converterBusy    <= 1'b0;
			setupWord        <= 16'h058A;
		end else begin
			// ready low when fresh data, then data bits once clocking
			serialOutReady   <= frameStarted_reg ? shiftOut_reg[31] : ~dataFresh_reg;
			serialOutReadyOe <= selected;
			// weak pull only when deselected and enabled; deselected without it floats
			serialOutPullup  <= ~selected & setup_reg[`ACFG_PULL_BIT];
			case (setup_reg[`ACFG_INSEL_HI:`ACFG_INSEL_LO])
				3'h0: begin inputPositive <= 3'h0; inputNegative <= 3'h1; end
				3'h1: begin inputPositive <= 3'h0; inputNegative <= 3'h3; end
				3'h2: begin inputPositive <= 3'h1; inputNegative <= 3'h3; end
				3'h3: begin inputPositive <= 3'h2; inputNegative <= 3'h3; end
				3'h4: begin inputPositive <= 3'h0; inputNegative <= `ACFG_IN_GND; end
				3'h5: begin inputPositive <= 3'h1; inputNegative <= `ACFG_IN_GND; end
				3'h6: begin inputPositive <= 3'h2; inputNegative <= `ACFG_IN_GND; end
				default: begin inputPositive <= 3'h3; inputNegative <= `ACFG_IN_GND; end
			endcase
			case (setup_reg[`ACFG_GAIN_HI:`ACFG_GAIN_LO])
				3'h0: fullScaleRange <= `ACFG_FSR_6144;
				3'h1: fullScaleRange <= `ACFG_FSR_4096;
				3'h2: fullScaleRange <= `ACFG_FSR_2048;
				3'h3: fullScaleRange <= `ACFG_FSR_1024;
				3'h4: fullScaleRange <= `ACFG_FSR_512;
				default: fullScaleRange <= `ACFG_FSR_256;
			endcase
			case (setup_reg[`ACFG_RATE_HI:`ACFG_RATE_LO])
				3'h0: samplesPerSecond <= 10'd8;
				3'h1: samplesPerSecond <= 10'd16;
				3'h2: samplesPerSecond <= 10'd32;
				3'h3: samplesPerSecond <= 10'd64;
				3'h4: samplesPerSecond <= 10'd128;
				3'h5: samplesPerSecond <= 10'd250;
				3'h6: samplesPerSecond <= 10'd475;
				default: samplesPerSecond <= 10'd860;
			endcase
			tempSenseSelect  <= setup_reg[`ACFG_TEMP_BIT];
			singleShotMode   <= setup_reg[`ACFG_MODE_BIT];
			converterBusy    <= convActive_reg;
			setupWord        <= readback;
		end
	end

endmodule
`default_nettype wire

// ===== sim/adccfg_setup_asserts.sv
// Purpose: port checks for the setup register
// Assumes: decode and setupWord update on the same clk
// Notes: readback bit 0 ignored
`timescale 1ns/100ps
`default_nettype none
module adccfg_setup_asserts (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// watched outputs
	input wire logic        serialOutReadyOe,
	input wire logic        serialOutPullup,
	input wire logic [15:0] setupWord,
	input wire logic [2:0]  inputPositive,
	input wire logic [2:0]  inputNegative,
	input wire logic [15:0] fullScaleRange,
	input wire logic        tempSenseSelect,
	input wire logic        singleShotMode,
	input wire logic        converterBusy
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// expected pair per code; gain past 101 saturates at 256 mV
	localparam logic [5:0] PAIR [8] = '{6'h01, 6'h03, 6'h0B, 6'h13, 6'h04, 6'h0C, 6'h14, 6'h1C};
	logic [2:0]  g;
	logic [15:0] full_scale_range;
	assign g = setupWord[11:9];
	assign full_scale_range = g == 3'h0 ? 16'h1800 : 16'h1000 >> (g > 3'h5 ? 3'h4 : g - 3'h1);
	property p_start; setupWord[15] == 1'b0; endproperty
	a_start: assert property (p_start) else $error("start bit read as one");
	property p_ins; $stable(setupWord) |-> {inputPositive, inputNegative} == PAIR[setupWord[14:12]]; endproperty
	a_ins: assert property (p_ins) else $error("input pair wrong");
	property p_fsr; $stable(setupWord) |-> fullScaleRange == full_scale_range; endproperty
	a_fsr: assert property (p_fsr) else $error("range wrong");
	property p_mode; $stable(setupWord) |-> singleShotMode == setupWord[8]; endproperty
	a_mode: assert property (p_mode) else $error("mode wrong");
	property p_temp; $stable(setupWord) |-> tempSenseSelect == setupWord[4]; endproperty
	a_temp: assert property (p_temp) else $error("temp select wrong");
	property p_pull; serialOutPullup |-> !serialOutReadyOe && (setupWord[3] || $past(setupWord[3])); endproperty
	a_pull: assert property (p_pull) else $error("pull-up misapplied");
	property p_wvc; !$stable(setupWord) |-> setupWord[2:1] == 2'b01; endproperty
	a_wvc: assert property (p_wvc) else $error("update without valid code");
	property p_cont; !singleShotMode && $past(!singleShotMode) |-> converterBusy; endproperty
	a_cont: assert property (p_cont) else $error("continuous idle");
	c_write: cover property (!$stable(setupWord));
	c_shot: cover property (singleShotMode && $rose(converterBusy));
	c_cont: cover property (!singleShotMode && converterBusy);
endmodule
bind adccfg_setup_reg adccfg_setup_asserts u_chk (.clk, .rst, .serialOutReadyOe, .serialOutPullup, .setupWord,
	.inputPositive, .inputNegative, .fullScaleRange, .tempSenseSelect, .singleShotMode, .converterBusy);
`default_nettype wire

// ===== sim/adccfg_spi_host.sv
// Purpose: host model driving the serial link
// Assumes: started on a falling clk edge, 800 ns sclk
// Notes: reads dout late in the high half
`timescale 1ns/100ps
`default_nettype none
module adccfg_spi_host (
	// serial link
	output logic      sclk,
	output logic      csN,
	output logic      din,
	input  wire logic dout
);
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		din = 1'b1;
	end
	// change on rise; the device answers some clocks late, so read just before fall
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		csN = 1'b0;
		#400;
		for (int i = 31; i >= 0; i--) begin
			sclk = 1'b1;
			din = tx[i];
			#400;
			rx[i] = dout;
			sclk = 1'b0;
			#400;
		end
		csN = 1'b1;
		din = ~din; // released line shows no stale level
	endtask
endmodule
`default_nettype wire

// ===== sim/test_adccfg_setup_reg.sv
// Purpose: self-checking bench for the setup register
// Assumes: host model drives the link; result tied to A5C3
// Notes: readback bit 0 is masked off
`timescale 1ns/100ps
`default_nettype none
module test_adccfg_setup_reg;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	wire logic   sclk, csN, din, pin;
	logic        serialOutReady, serialOutReadyOe, serialOutPullup, tempSenseSelect, singleShotMode, converterBusy;
	logic [2:0]  inputPositive, inputNegative;
	logic [9:0]  samplesPerSecond;
	logic [15:0] fullScaleRange, setupWord;
	logic [31:0] rx;
	int          badCount = 0;
	int          samplesChecked = 0;
	// floating pin shows the inverse of its last level
	assign pin = serialOutReadyOe ? serialOutReady : serialOutPullup | ~serialOutReady;
	initial forever #50 clk = ~clk;
	adccfg_spi_host host (.sclk, .csN, .din, .dout(pin));
	adccfg_setup_reg #(.CONV_CYCLES(300)) DUT (.clk, .rst, .sclk, .csN, .din, .conversionResult(16'hA5C3),
		.serialOutReady, .serialOutReadyOe, .serialOutPullup, .inputPositive, .inputNegative, .fullScaleRange,
		.samplesPerSecond, .tempSenseSelect, .singleShotMode, .converterBusy, .setupWord);
	task automatic chk(input string what, input logic [31:0] exp, got);
		samplesChecked++;
		if (got !== exp) begin
			badCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic completeRun();
		$display("checks %0d mismatches %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// bounded wait; a spent bound ends the run
	task automatic waitBusy(input logic v);
		int n;
		n = 0;
		while (converterBusy !== v && n < 500) begin
			@(negedge clk);
			n++;
		end
		chk("busy", v, converterBusy);
		if (n == 500) completeRun();
	endtask
	task automatic frame(input logic [31:0] tx);
		@(negedge clk);
		host.xfer(tx, rx);
		repeat (6) @(negedge clk);
	endtask
	task automatic tReset();
		chk("setup", 16'h058A, setupWord & 16'hFFFE);
		chk("fsr", 16'h0800, fullScaleRange);
		chk("sps", 10'h080, samplesPerSecond);
		chk("pull", 1'b1, serialOutPullup);
		chk("oe", 1'b0, serialOutReadyOe);
		chk("pair", 6'h01, {inputPositive, inputNegative});
		chk("mode", 2'b01, {tempSenseSelect, singleShotMode});
		$display("reset test done");
	endtask
	task automatic tWrite();
		frame({16'h3AF3, 16'h3AF3});
		chk("readback", 16'h3AF2, rx[15:0] & 16'hFFFE);
		chk("pair", 6'h13, {inputPositive, inputNegative});
		chk("fsr", 16'h0100, fullScaleRange);
		chk("sps", 10'h35C, samplesPerSecond);
		chk("mode", 2'b10, {tempSenseSelect, singleShotMode});
		chk("pull", 1'b0, serialOutPullup);
		waitBusy(1'b1);
		repeat (400) @(negedge clk);
		frame(32'h0);
		chk("result", 32'hA5C3_3AF2, rx & 32'hFFFF_FFFE);
		$display("write test done");
	endtask
	task automatic tNop();
		logic [31:0] tx [3] = '{32'hFFFF_FFFF, 32'h0585_0585, 32'h0007_0007};
		foreach (tx[i]) begin
			frame(tx[i]);
			chk("kept", 16'h3AF2, setupWord & 16'hFFFE);
		end
		$display("skip test done");
	endtask
	task automatic tSingle();
		frame({16'h058B, 16'h0});
		waitBusy(1'b0);
		frame({16'h058B, 16'h0});
		chk("no start", 1'b0, converterBusy);
		frame({16'h858B, 16'h0});
		waitBusy(1'b1);
		chk("setup", 16'h058A, setupWord & 16'hFFFE);
		chk("pull", 1'b1, serialOutPullup);
		$display("single test done");
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		tReset();
		tWrite();
		tNop();
		tSingle();
		completeRun();
	end
endmodule
`default_nettype wire
